/* common/svcr_pkg.sv */
// Package of offsets, field layouts and reset values for the vendor configuration registers.
package svcr_pkg;

  // ****************************************************************
  // Register offsets (byte addresses in configuration space)
  // ****************************************************************
  localparam logic [7:0] SVCR_OFF_TUNING_A   = 8'hD4;
  localparam logic [7:0] SVCR_OFF_TUNING_B   = 8'hD8;
  localparam logic [7:0] SVCR_OFF_TUNING_C   = 8'hDC;
  localparam logic [7:0] SVCR_OFF_SUBSYS     = 8'hE0;
  localparam logic [7:0] SVCR_OFF_GEN_CTRL   = 8'hE4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] SVCR_RST_TUNING_A  = 32'h0000_0010;
  localparam logic [31:0] SVCR_RST_TUNING_B  = 32'h0000_0000;
  localparam logic [31:0] SVCR_RST_TUNING_C  = 32'h0000_0002;
  localparam logic [31:0] SVCR_RST_SUBSYS    = 32'h0000_0000;
  localparam logic [31:0] SVCR_RST_GEN_CTRL  = 32'h0000_0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SVCR_SSID_LSB               = 16;
  localparam int SVCR_SSVID_LSB              = 0;
  localparam int SVCR_GC_L1_BLOCK_BIT        = 1;
  localparam int SVCR_GC_VENDOR_BIT          = 2;
  localparam logic [31:0] SVCR_GC_WR_MASK    = 32'h0000_0006;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } svcr_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } svcr_preload_t;

  typedef struct packed {
    logic [15:0] subsystem_identifier;
    logic [15:0] subsystem_vendor_identifier;
  } svcr_subsys_t;

endpackage : svcr_pkg

/* hw/svcr_regs.sv */
// Vendor configuration register bank of the switch upstream port.
`timescale 1ns/1ns

// Function
// - Fundamental reset returns each tuning register to its default value.
// - After reset the first tuning register reads with only bit 4 set.
// - After reset the third tuning register reads 2 and the second reads zero.
// - The subsystem identity register is mirrored to every port's subsystem ID registers.
// - The upper half holds the subsystem identifier and the lower half the vendor identifier.
// - Both identity fields load from EEPROM when present and clear on fundamental reset.
// - General control bits 31 to 3 and bit 0 always read zero.
// - With the L1 block bit clear, link power follows the base rules.
// - With the L1 block bit set, the upstream port refuses L1 entry even in D1 to D3.
module svcr_regs
  import svcr_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire svcr_cfg_req_t         cfg_req,
  output logic                       cfg_ack,
  output logic [31:0]                cfg_rdata,
  input  wire svcr_preload_t         preload,
  input  wire logic                  l1_entry_request,
  output logic                       l1_entry_grant,
  output svcr_subsys_t [NUM_PORTS-1:0] port_subsys,
  output logic                       low_power_link_block,
  output logic                       vendor_reserved_control
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] svcr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : svcr_merge

  function automatic logic svcr_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : svcr_hit

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0] tuning_a_reg;
  logic [31:0] tuning_b_reg;
  logic [31:0] tuning_c_reg;
  logic [31:0] subsys_reg;
  logic [31:0] gen_ctrl_reg;
  logic        wr_en;
  logic [3:0]  wr_be;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;

  // A preload from the EEPROM engine uses the same path as a config write,
  // with all byte lanes; it takes priority since loading precedes enumeration.
  always_comb begin
    if (preload.valid) begin
      wr_en   = 1'b1;
      wr_be   = 4'hF;
      wr_addr = preload.addr;
      wr_data = preload.data;
    end else begin
      wr_en   = cfg_req.wr;
      wr_be   = cfg_req.byte_en;
      wr_addr = cfg_req.addr;
      wr_data = cfg_req.wdata;
    end
  end

  // ****************************************************************
  // Tuning registers
  // ****************************************************************
  // Contents are stored as written; the device cannot enforce that software
  // keeps the defaults, it only guarantees reset restores them.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tuning_a_reg <= SVCR_RST_TUNING_A;
      tuning_b_reg <= SVCR_RST_TUNING_B;
      tuning_c_reg <= SVCR_RST_TUNING_C;
    end else if (wr_en) begin
      if (svcr_hit(wr_addr, SVCR_OFF_TUNING_A)) begin
        tuning_a_reg <= svcr_merge(tuning_a_reg, wr_data, wr_be);
      end
      if (svcr_hit(wr_addr, SVCR_OFF_TUNING_B)) begin
        tuning_b_reg <= svcr_merge(tuning_b_reg, wr_data, wr_be);
      end
      if (svcr_hit(wr_addr, SVCR_OFF_TUNING_C)) begin
        tuning_c_reg <= svcr_merge(tuning_c_reg, wr_data, wr_be);
      end
    end
  end

  // ****************************************************************
  // Subsystem identity
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      subsys_reg <= SVCR_RST_SUBSYS;
    end else if (wr_en && svcr_hit(wr_addr, SVCR_OFF_SUBSYS)) begin
      subsys_reg <= svcr_merge(subsys_reg, wr_data, wr_be);
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!reset_n) begin
        port_subsys[p] <= '0;
      end else begin
        port_subsys[p].subsystem_identifier <= subsys_reg[SVCR_SSID_LSB +: 16];
        port_subsys[p].subsystem_vendor_identifier <= subsys_reg[SVCR_SSVID_LSB +: 16];
      end
    end
  end

  // ****************************************************************
  // General control
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gen_ctrl_reg <= SVCR_RST_GEN_CTRL;
    end else if (wr_en && svcr_hit(wr_addr, SVCR_OFF_GEN_CTRL)) begin
      gen_ctrl_reg <= svcr_merge(gen_ctrl_reg, wr_data, wr_be) & SVCR_GC_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_power_link_block    <= 1'b0;
      vendor_reserved_control <= 1'b0;
      l1_entry_grant          <= 1'b0;
    end else begin
      low_power_link_block    <= gen_ctrl_reg[SVCR_GC_L1_BLOCK_BIT];
      vendor_reserved_control <= gen_ctrl_reg[SVCR_GC_VENDOR_BIT];
      // Requests pass untouched unless blocked; the request already encodes
      // the base power-management decision.
      l1_entry_grant <= l1_entry_request && !gen_ctrl_reg[SVCR_GC_L1_BLOCK_BIT];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped offsets inside the window read zero so other banks can be ORed.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= '0;
    end else begin
      cfg_ack   <= cfg_req.rd || cfg_req.wr;
      cfg_rdata <= '0;
      if (cfg_req.rd) begin
        if (svcr_hit(cfg_req.addr, SVCR_OFF_TUNING_A)) begin
          cfg_rdata <= tuning_a_reg;
        end else if (svcr_hit(cfg_req.addr, SVCR_OFF_TUNING_B)) begin
          cfg_rdata <= tuning_b_reg;
        end else if (svcr_hit(cfg_req.addr, SVCR_OFF_TUNING_C)) begin
          cfg_rdata <= tuning_c_reg;
        end else if (svcr_hit(cfg_req.addr, SVCR_OFF_SUBSYS)) begin
          cfg_rdata <= subsys_reg;
        end else if (svcr_hit(cfg_req.addr, SVCR_OFF_GEN_CTRL)) begin
          cfg_rdata <= gen_ctrl_reg & SVCR_GC_WR_MASK;
        end
      end
    end
  end

endmodule : svcr_regs

/* test/svcr_regs_checker.sv */
// Port assertions of the vendor configuration register bank.
`timescale 1ns/1ns
module svcr_checker
  import svcr_pkg::*;
#(parameter int NUM_PORTS = 4) (
  input wire logic                          clk,
  input wire logic                          reset_n,
  input wire svcr_cfg_req_t                 cfg_req,
  input wire logic                          cfg_ack,
  input wire logic [31:0]                   cfg_rdata,
  input wire svcr_preload_t                 preload,
  input wire logic                          l1_entry_request,
  input wire logic                          l1_entry_grant,
  input wire svcr_subsys_t [NUM_PORTS-1:0]  port_subsys,
  input wire logic                          low_power_link_block,
  input wire logic                          vendor_reserved_control
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence gc_wr;
    cfg_req.wr && cfg_req.addr[7:2] == 6'h39 && cfg_req.byte_en[0] && !preload.valid;
  endsequence
  sequence id_wr;
    cfg_req.wr && cfg_req.addr[7:2] == 6'h38 && cfg_req.byte_en == 4'hF && !preload.valid;
  endsequence
  ack_pulse_a: assert property ($past(reset_n) |-> cfg_ack == $past(cfg_req.rd || cfg_req.wr))
    else $error("ack does not follow request");
  rdata_idle_a: assert property (!cfg_ack |-> cfg_rdata == 32'h0)
    else $error("read data not zero while idle");
  reserved_zero_a: assert property (
    cfg_ack && $past(cfg_req.rd && cfg_req.addr[7:2] == 6'h39) |-> cfg_rdata[31:3] == 29'h0 && !cfg_rdata[0])
    else $error("reserved control bits read nonzero");
  block_grant_a: assert property (low_power_link_block |-> !l1_entry_grant)
    else $error("grant while blocked");
  grant_follow_a: assert property (
    $past(reset_n) |-> l1_entry_grant == ($past(l1_entry_request) && !low_power_link_block))
    else $error("grant does not follow request");
  ctrl_copy_a: assert property (gc_wr |=> ##1 low_power_link_block == $past(cfg_req.wdata[1], 2) &&
    vendor_reserved_control == $past(cfg_req.wdata[2], 2)) else $error("control copy wrong");
  mirror_copy_a: assert property (id_wr |=> ##1 port_subsys[0] == $past(cfg_req.wdata, 2) &&
    port_subsys[NUM_PORTS-1] == $past(cfg_req.wdata, 2)) else $error("mirror wrong");
  reset_clear_a: assert property ($past(!reset_n) |-> !cfg_ack && !low_power_link_block &&
    !l1_entry_grant && port_subsys[0] == 32'h0) else $error("outputs not cleared by reset");
endmodule : svcr_checker
bind svcr_regs svcr_checker #(.NUM_PORTS(NUM_PORTS)) i_chk (.clk, .reset_n, .cfg_req, .cfg_ack,
  .cfg_rdata, .preload, .l1_entry_request, .l1_entry_grant, .port_subsys, .low_power_link_block,
  .vendor_reserved_control);

/* test/svcr_host.sv */
// Host model issuing configuration accesses and serial EEPROM preloads.
`timescale 1ns/1ns
module svcr_host
  import svcr_pkg::*;
(
  input wire logic         clk,
  input wire logic         cfg_ack,
  input wire logic [31:0]  cfg_rdata,
  output svcr_cfg_req_t    cfg_req,
  output svcr_preload_t    preload
);
  initial begin
    cfg_req = '0;
    preload = '0;
  end
  // Address, enable and data lines show the inverse of the last request once taken, with rd, wr and valid cleared, so stale values never pass.
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q, output logic ack);
    @(posedge clk) cfg_req <= '{rd: !w, wr: w, addr: a, byte_en: be, wdata: d};
    @(posedge clk) cfg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, byte_en: ~be, wdata: ~d};
    @(posedge clk) q = cfg_rdata;
    ack = cfg_ack;
  endtask : access
  task automatic load(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) preload <= '{valid: 1'b1, addr: a, data: d};
    @(posedge clk) preload <= '{valid: 1'b0, addr: ~a, data: ~d};
  endtask : load
endmodule : svcr_host

/* test/test_svcr_regs.sv */
// Self-checking testbench of the vendor configuration register bank.
`timescale 1ns/1ns
module test_svcr_regs
  import svcr_pkg::*;
;
  localparam int NP = 2;
  logic clk = 1'b0, reset_n = 1'b0, l1_entry_request = 1'b0;
  logic cfg_ack, l1_entry_grant, low_power_link_block, vendor_reserved_control;
  logic [31:0] cfg_rdata;
  svcr_cfg_req_t cfg_req;
  svcr_preload_t preload;
  svcr_subsys_t [NP-1:0] port_subsys;
  int fails = 0, total_checks = 0, cycles = 0;
  logic [7:0] offs [5] = '{8'hD4, 8'hD8, 8'hDC, 8'hE0, 8'hE4};
  logic [31:0] rstv [5] = '{32'h00000010, 32'h0, 32'h00000002, 32'h0, 32'h0};
  always #25 clk = ~clk;
  svcr_host i_host (.clk, .cfg_ack, .cfg_rdata, .cfg_req, .preload);
  svcr_regs #(.NUM_PORTS(NP)) i_dut (.clk, .reset_n, .cfg_req, .cfg_ack, .cfg_rdata, .preload,
    .l1_entry_request, .l1_entry_grant, .port_subsys, .low_power_link_block,
    .vendor_reserved_control);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
    logic [31:0] q;
    logic ack;
    i_host.access(w, a, be, d, q, ack);
    check("ack", 32'h1, {31'h0, ack});
    if (!w) check("read data", d, q);
  endtask : xfer
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      $display("mismatch timeout expected %0d seen %0d", 1999, cycles);
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) xfer(1'b0, offs[i], 4'hF, rstv[i]);
    xfer(1'b0, 8'hF0, 4'hF, 32'h0);
    $display("test reset values done");
    xfer(1'b1, 8'hE0, 4'hF, 32'hBEEF1234);
    xfer(1'b1, 8'hE0, 4'h4, 32'h00AA0000);
    xfer(1'b0, 8'hE0, 4'hF, 32'hBEAA1234);
    for (int i = 0; i < NP; i++) check("mirror", 32'hBEAA1234, port_subsys[i]);
    $display("test identity done");
    l1_entry_request <= 1'b1;
    // Software keeps the vendor control bit at zero, so only the reserved bits and the L1 block bit are written as ones.
    xfer(1'b1, 8'hE4, 4'hF, 32'hFFFFFFFB);
    xfer(1'b0, 8'hE4, 4'hF, 32'h00000002);
    check("controls", 32'h1, {30'h0, vendor_reserved_control, low_power_link_block});
    check("grant", 32'h0, {31'h0, l1_entry_grant});
    xfer(1'b1, 8'hE4, 4'hF, 32'h0);
    xfer(1'b0, 8'hE4, 4'hF, 32'h0);
    check("grant", 32'h1, {31'h0, l1_entry_grant});
    $display("test link block done");
    xfer(1'b1, 8'hD4, 4'hF, 32'hFFFFFFFF);
    xfer(1'b0, 8'hD4, 4'hF, 32'hFFFFFFFF);
    i_host.load(8'hD4, 32'h00001000);
    xfer(1'b0, 8'hD4, 4'hF, 32'h00001000);
    i_host.load(8'hE0, 32'h12345678);
    xfer(1'b0, 8'hE0, 4'hF, 32'h12345678);
    check("mirror", 32'h12345678, port_subsys[NP-1]);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) xfer(1'b0, offs[i], 4'hF, rstv[i]);
    $display("test preload and reset done");
    summarize();
  end
endmodule : test_svcr_regs
